// ---- rdac_defs.svh ----
// register map, field positions and reset values of the receiver adaptation config bank
`ifndef RDAC_DEFS_SVH
`define RDAC_DEFS_SVH

`define RDAC_DATA_W            16
`define RDAC_ADDR_W            16
`define RDAC_NUM_REGS          5

// register offsets on the management interface
`define RDAC_OFF_SWEEP         16'h030f
`define RDAC_OFF_GAINMAP       16'h0311
`define RDAC_OFF_FORCED        16'h0313
`define RDAC_OFF_TLOOP         16'h031c
`define RDAC_OFF_LPI           16'h031f

// register indices inside the bank
`define RDAC_IDX_SWEEP         0
`define RDAC_IDX_GAINMAP       1
`define RDAC_IDX_FORCED        2
`define RDAC_IDX_TLOOP         3
`define RDAC_IDX_LPI           4

// reset values (only the bits held by this bank)
`define RDAC_RST_SWEEP         16'h0064
`define RDAC_RST_GAINMAP       16'h01fc
`define RDAC_RST_FORCED        16'h06f8
`define RDAC_RST_TLOOP         16'h1101
`define RDAC_RST_LPI           16'hfc36

// writable bits; everything else is reserved and reads zero
`define RDAC_WM_SWEEP          16'h007f
`define RDAC_WM_GAINMAP        16'he1fe
`define RDAC_WM_FORCED         16'hffff
`define RDAC_WM_TLOOP          16'hffff
`define RDAC_WM_LPI            16'hfffe

// adaptation freeze and sweep register fields
`define RDAC_F_STATE2_HOLD     6
`define RDAC_F_STATE3_HOLD     5
`define RDAC_F_CHECK_HI        4
`define RDAC_F_CHECK_LO        2
`define RDAC_F_FREQACC_CLR     1
`define RDAC_F_DFE_RESET       0

// gain map and coefficient select fields
`define RDAC_F_GAINMAP_HI      15
`define RDAC_F_GAINMAP_LO      14
`define RDAC_F_COEFF_SRC       13
`define RDAC_F_C0_SHORT_HI     8
`define RDAC_F_C0_SHORT_LO     1
`define RDAC_GAINMAP_ILLEGAL   2'h3

// forced coefficient fields
`define RDAC_F_C0_LONG_HI      15
`define RDAC_F_C0_LONG_LO      8
`define RDAC_F_C1_SHORT_HI     7
`define RDAC_F_C1_SHORT_LO     0

// timing loop fields
`define RDAC_F_KP_FORCE_EN     15
`define RDAC_F_KF_FORCE_EN     14
`define RDAC_F_KP_VAL_HI       13
`define RDAC_F_KP_VAL_LO       11
`define RDAC_F_KF_VAL_HI       10
`define RDAC_F_KF_VAL_LO       7
`define RDAC_F_KP_HOLD_EN      6
`define RDAC_F_KP_HOLD_VAL     5
`define RDAC_F_KF_HOLD_EN      4
`define RDAC_F_KF_HOLD_VAL     3
`define RDAC_F_PD_INVERT       2
`define RDAC_F_ENERGY_SEL      1
`define RDAC_F_PRECURSOR_EN    0

// low-power-idle freeze group fields
`define RDAC_F_HOLDGRP_HI      15
`define RDAC_F_HOLDGRP_LO      11
`define RDAC_F_WAKEGRP_HI      10
`define RDAC_F_WAKEGRP_LO      6
`define RDAC_F_FLUSHGRP_HI     5
`define RDAC_F_FLUSHGRP_LO     1

`endif

// ---- rdac_pkg.sv ----
// types shared by the receiver adaptation config bank
`default_nettype none
package rdac_pkg;

	// adaptation sequencer state reported by the equalizer engine
	typedef enum logic [2:0] {
		RDAC_ADAPT_IDLE   = 3'b000,
		RDAC_ADAPT_FFE1   = 3'b001,
		RDAC_ADAPT_FFE2   = 3'b010,
		RDAC_ADAPT_FFE3   = 3'b011,
		RDAC_ADAPT_SWEEP  = 3'b100,
		RDAC_ADAPT_STEADY = 3'b101
	} rdac_adapt_type;

	// low-power-idle sequencer state
	typedef enum logic [1:0] {
		RDAC_LPI_ACTIVE = 2'b00,
		RDAC_LPI_HOLD   = 2'b01,
		RDAC_LPI_WAKE   = 2'b10,
		RDAC_LPI_FLUSH  = 2'b11
	} rdac_lpi_type;

	// cable length class from the length estimator
	typedef enum logic [1:0] {
		RDAC_CABLE_SHORT = 2'b00,
		RDAC_CABLE_MID   = 2'b01,
		RDAC_CABLE_LONG  = 2'b10
	} rdac_cable_type;

	// freeze groups, msb first as laid out in the register
	typedef struct packed {
		logic ffe;
		logic integ_arm;
		logic prop_arm;
		logic dfe;
		logic gain_blocks;
	} rdac_groups_type;

	// management access request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        write;
		logic        read;
	} rdac_mgmt_type;

	// metric checks enabled during the equalizer sweep
	typedef struct packed {
		logic precursor;
		logic mse;
		logic dfe_coeff;
	} rdac_checks_type;

endpackage : rdac_pkg
`default_nettype wire

// ---- rdac_reg_word.sv ----
// one configuration word with reset value and writable-bit mask
`default_nettype none
`include "rdac_defs.svh"
module rdac_reg_word #(
	parameter logic [15:0] RESET_VALUE = 16'h0000,
	parameter logic [15:0] WRITE_MASK  = 16'hffff
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// write side
	input  wire logic        write_en,
	input  wire logic [15:0] wdata,
	// stored word
	output logic      [15:0] value
);

	// reserved bits are masked out of both reset and write so they always read zero
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			value <= RESET_VALUE & WRITE_MASK;
		else if (write_en)
			value <= wdata & WRITE_MASK;
	end

endmodule : rdac_reg_word
`default_nettype wire

// ---- rdac_top.sv ----
// receiver adaptation configuration bank and the steering it applies to the dsp
`default_nettype none
`include "rdac_defs.svh"
module rdac_top #(
	parameter int COEFF_WIDTH = 8,
	parameter int KP_WIDTH    = 3,
	parameter int KF_WIDTH    = 4
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	// management register access
	input  wire rdac_pkg::rdac_mgmt_type mgmt_req,
	output logic [15:0]                mgmt_rdata,
	output logic                       mgmt_rvalid,
	// status from the adaptation engine
	input  wire rdac_pkg::rdac_adapt_type adapt_state,
	input  wire logic                  sweep_iter_start,
	input  wire rdac_pkg::rdac_cable_type cable_class,
	input  wire rdac_pkg::rdac_lpi_type lpi_state,
	input  wire logic [KP_WIDTH-1:0]   adaptive_prop_gain,
	input  wire logic [KF_WIDTH-1:0]   adaptive_integ_gain,
	input  wire logic                  adaptive_prop_hold,
	input  wire logic                  adaptive_integ_hold,
	// equalizer steering
	output logic                       ffe_hold,
	output logic                       dfe_hold,
	output logic                       gain_blocks_hold,
	output rdac_pkg::rdac_checks_type  sweep_checks,
	output logic                       precursor_metric_enable,
	output logic                       freqacc_clear,
	output logic                       dfe_coeff_reset,
	output logic [1:0]                 gain_map_sel,
	output logic                       coeff_source_table,
	output logic [COEFF_WIDTH-1:0]     forced_coeff0,
	output logic                       forced_coeff0_valid,
	output logic [COEFF_WIDTH-1:0]     forced_coeff1,
	output logic                       forced_coeff1_valid,
	// timing loop steering
	output logic [KP_WIDTH-1:0]        prop_gain,
	output logic [KF_WIDTH-1:0]        integ_gain,
	output logic                       prop_arm_hold,
	output logic                       integ_arm_hold,
	output logic                       phase_detector_invert,
	output logic                       energy_input_adc
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (COEFF_WIDTH != `RDAC_F_C0_LONG_HI - `RDAC_F_C0_LONG_LO + 1)
		$error("coefficient width must match the register field");
	if (KP_WIDTH != `RDAC_F_KP_VAL_HI - `RDAC_F_KP_VAL_LO + 1)
		$error("proportional gain width must match the register field");
	if (KF_WIDTH != `RDAC_F_KF_VAL_HI - `RDAC_F_KF_VAL_LO + 1)
		$error("integral gain width must match the register field");

	////////////////////////////////////////////////////////////////////////////
	// register bank

	localparam logic [15:0] REG_OFFSET [`RDAC_NUM_REGS] = '{
		`RDAC_OFF_SWEEP, `RDAC_OFF_GAINMAP, `RDAC_OFF_FORCED, `RDAC_OFF_TLOOP, `RDAC_OFF_LPI};
	localparam logic [15:0] REG_RESET [`RDAC_NUM_REGS] = '{
		`RDAC_RST_SWEEP, `RDAC_RST_GAINMAP, `RDAC_RST_FORCED, `RDAC_RST_TLOOP, `RDAC_RST_LPI};
	localparam logic [15:0] REG_MASK [`RDAC_NUM_REGS] = '{
		`RDAC_WM_SWEEP, `RDAC_WM_GAINMAP, `RDAC_WM_FORCED, `RDAC_WM_TLOOP, `RDAC_WM_LPI};

	logic [15:0]              reg_value [`RDAC_NUM_REGS];
	logic [`RDAC_NUM_REGS-1:0] reg_hit;
	logic [15:0]              reg_wdata [`RDAC_NUM_REGS];
	logic [15:0]              next_rdata;

	for (genvar i = 0; i < `RDAC_NUM_REGS; i++)
	begin : g_reg
		assign reg_hit[i] = (mgmt_req.addr == REG_OFFSET[i]);

		// the gain map select has no fourth code: a write of it keeps the old select
		if (i == `RDAC_IDX_GAINMAP)
		begin : g_gainmap
			assign reg_wdata[i] = (mgmt_req.wdata[`RDAC_F_GAINMAP_HI:`RDAC_F_GAINMAP_LO]
				== `RDAC_GAINMAP_ILLEGAL)
				? {reg_value[i][`RDAC_F_GAINMAP_HI:`RDAC_F_GAINMAP_LO],
				   mgmt_req.wdata[`RDAC_F_GAINMAP_LO-1:0]}
				: mgmt_req.wdata;
		end
		else
		begin : g_plain
			assign reg_wdata[i] = mgmt_req.wdata;
		end

		rdac_reg_word #(
			.RESET_VALUE (REG_RESET[i]),
			.WRITE_MASK  (REG_MASK[i])
		) u_word (
			.clock    (clock),
			.sys_rst  (sys_rst),
			.write_en (mgmt_req.write & reg_hit[i]),
			.wdata    (reg_wdata[i]),
			.value    (reg_value[i])
		);
	end

	// unmapped addresses read zero
	always_comb
	begin
		next_rdata = 16'h0000;
		for (int i = 0; i < `RDAC_NUM_REGS; i++)
			if (reg_hit[i])
				next_rdata = reg_value[i];
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			mgmt_rdata  <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end
		else
		begin
			mgmt_rvalid <= mgmt_req.read;
			if (mgmt_req.read)
				mgmt_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field views

	logic [15:0] sweep_reg;
	logic [15:0] gainmap_reg;
	logic [15:0] forced_reg;
	logic [15:0] tloop_reg;
	logic [15:0] lpi_reg;

	assign sweep_reg   = reg_value[`RDAC_IDX_SWEEP];
	assign gainmap_reg = reg_value[`RDAC_IDX_GAINMAP];
	assign forced_reg  = reg_value[`RDAC_IDX_FORCED];
	assign tloop_reg   = reg_value[`RDAC_IDX_TLOOP];
	assign lpi_reg     = reg_value[`RDAC_IDX_LPI];

	////////////////////////////////////////////////////////////////////////////
	// low-power-idle freeze groups

	rdac_pkg::rdac_groups_type next_groups;

	always_comb
	begin
		unique case (lpi_state)
			rdac_pkg::RDAC_LPI_ACTIVE:
				next_groups = '0;
			rdac_pkg::RDAC_LPI_HOLD:
				next_groups = lpi_reg[`RDAC_F_HOLDGRP_HI:`RDAC_F_HOLDGRP_LO];
			rdac_pkg::RDAC_LPI_WAKE:
				next_groups = lpi_reg[`RDAC_F_WAKEGRP_HI:`RDAC_F_WAKEGRP_LO];
			rdac_pkg::RDAC_LPI_FLUSH:
				next_groups = lpi_reg[`RDAC_F_FLUSHGRP_HI:`RDAC_F_FLUSHGRP_LO];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// equalizer freeze by adaptation state

	logic next_ffe_state_hold;

	always_comb
	begin
		unique case (adapt_state)
			rdac_pkg::RDAC_ADAPT_FFE2:
				next_ffe_state_hold = sweep_reg[`RDAC_F_STATE2_HOLD];
			rdac_pkg::RDAC_ADAPT_FFE3:
				next_ffe_state_hold = sweep_reg[`RDAC_F_STATE3_HOLD];
			rdac_pkg::RDAC_ADAPT_IDLE,
			rdac_pkg::RDAC_ADAPT_FFE1,
			rdac_pkg::RDAC_ADAPT_SWEEP,
			rdac_pkg::RDAC_ADAPT_STEADY:
				next_ffe_state_hold = 1'b0;
			default:
				next_ffe_state_hold = 1'b0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ffe_hold         <= 1'b0;
			dfe_hold         <= 1'b0;
			gain_blocks_hold <= 1'b0;
		end
		else
		begin
			ffe_hold         <= next_ffe_state_hold | next_groups.ffe;
			dfe_hold         <= next_groups.dfe;
			gain_blocks_hold <= next_groups.gain_blocks;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sweep checks and per-iteration actions

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sweep_checks            <= '0;
			precursor_metric_enable <= 1'b0;
			freqacc_clear           <= 1'b0;
			dfe_coeff_reset         <= 1'b0;
		end
		else
		begin
			sweep_checks            <= sweep_reg[`RDAC_F_CHECK_HI:`RDAC_F_CHECK_LO];
			precursor_metric_enable <= tloop_reg[`RDAC_F_PRECURSOR_EN];
			// one-cycle pulses, only while the sweep is running
			freqacc_clear   <= sweep_iter_start & sweep_reg[`RDAC_F_FREQACC_CLR] &
				(adapt_state == rdac_pkg::RDAC_ADAPT_SWEEP);
			dfe_coeff_reset <= sweep_iter_start & sweep_reg[`RDAC_F_DFE_RESET] &
				(adapt_state == rdac_pkg::RDAC_ADAPT_SWEEP);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// coefficient selection and forced coefficients

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			gain_map_sel        <= 2'h0;
			coeff_source_table  <= 1'b0;
			forced_coeff0       <= '0;
			forced_coeff0_valid <= 1'b0;
			forced_coeff1       <= '0;
			forced_coeff1_valid <= 1'b0;
		end
		else
		begin
			gain_map_sel       <= gainmap_reg[`RDAC_F_GAINMAP_HI:`RDAC_F_GAINMAP_LO];
			coeff_source_table <= gainmap_reg[`RDAC_F_COEFF_SRC];
			forced_coeff0_valid <= (cable_class == rdac_pkg::RDAC_CABLE_SHORT) |
				(cable_class == rdac_pkg::RDAC_CABLE_LONG);
			forced_coeff1_valid <= (cable_class == rdac_pkg::RDAC_CABLE_SHORT);
			forced_coeff1 <= forced_reg[`RDAC_F_C1_SHORT_HI:`RDAC_F_C1_SHORT_LO];
			// long cables hold no second coefficient here, so only the first switches
			if (cable_class == rdac_pkg::RDAC_CABLE_LONG)
				forced_coeff0 <= forced_reg[`RDAC_F_C0_LONG_HI:`RDAC_F_C0_LONG_LO];
			else
				forced_coeff0 <= gainmap_reg[`RDAC_F_C0_SHORT_HI:`RDAC_F_C0_SHORT_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timing loop gains and arm holds

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			prop_gain             <= '0;
			integ_gain            <= '0;
			prop_arm_hold         <= 1'b0;
			integ_arm_hold        <= 1'b0;
			phase_detector_invert <= 1'b0;
			energy_input_adc      <= 1'b0;
		end
		else
		begin
			prop_gain <= tloop_reg[`RDAC_F_KP_FORCE_EN]
				? tloop_reg[`RDAC_F_KP_VAL_HI:`RDAC_F_KP_VAL_LO]
				: adaptive_prop_gain;
			integ_gain <= tloop_reg[`RDAC_F_KF_FORCE_EN]
				? tloop_reg[`RDAC_F_KF_VAL_HI:`RDAC_F_KF_VAL_LO]
				: adaptive_integ_gain;
			// the idle sequencer can still freeze an arm that the override lets run
			prop_arm_hold <= (tloop_reg[`RDAC_F_KP_HOLD_EN]
				? tloop_reg[`RDAC_F_KP_HOLD_VAL]
				: adaptive_prop_hold) | next_groups.prop_arm;
			integ_arm_hold <= (tloop_reg[`RDAC_F_KF_HOLD_EN]
				? tloop_reg[`RDAC_F_KF_HOLD_VAL]
				: adaptive_integ_hold) | next_groups.integ_arm;
			phase_detector_invert <= tloop_reg[`RDAC_F_PD_INVERT];
			energy_input_adc      <= tloop_reg[`RDAC_F_ENERGY_SEL];
		end
	end

endmodule : rdac_top
`default_nettype wire

// ---- rdac_top_checker.sv ----
// port-level assertions for the receiver adaptation config bank
`default_nettype none
`include "rdac_defs.svh"
module rdac_top_checker #(
	parameter int COEFF_WIDTH = 8,
	parameter int KP_WIDTH    = 3,
	parameter int KF_WIDTH    = 4
) (
	// clock and reset
	input wire logic                     clock,
	input wire logic                     sys_rst,
	// management access
	input wire rdac_pkg::rdac_mgmt_type  mgmt_req,
	input wire logic [15:0]              mgmt_rdata,
	input wire logic                     mgmt_rvalid,
	// status inputs
	input wire rdac_pkg::rdac_adapt_type adapt_state,
	input wire logic                     sweep_iter_start,
	input wire rdac_pkg::rdac_cable_type cable_class,
	input wire rdac_pkg::rdac_lpi_type   lpi_state,
	// steering outputs
	input wire logic                     dfe_hold,
	input wire logic                     gain_blocks_hold,
	input wire logic                     freqacc_clear,
	input wire logic                     dfe_coeff_reset,
	input wire logic                     forced_coeff0_valid,
	input wire logic                     forced_coeff1_valid
);
	// outputs are still zero on the first edge after release, so skip it
	logic rst_q;

	always_ff @(posedge clock)
	begin
		rst_q <= sys_rst;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst || rst_q);

	////////////////////////////////////////////////////////////////////////////
	freq_pulse_a: assert property (freqacc_clear |-> $past(sweep_iter_start)
		&& $past(adapt_state) == rdac_pkg::RDAC_ADAPT_SWEEP) else $error("stray frequency clear");
	dfe_pulse_a: assert property (dfe_coeff_reset |-> $past(sweep_iter_start)
		&& $past(adapt_state) == rdac_pkg::RDAC_ADAPT_SWEEP) else $error("stray dfe reset");
	read_answer_a: assert property (mgmt_req.read |=> mgmt_rvalid)
		else $error("read not answered");
	rvalid_cause_a: assert property (mgmt_rvalid |-> $past(mgmt_req.read))
		else $error("read valid without request");
	unmapped_zero_a: assert property (mgmt_req.read && !(mgmt_req.addr inside
		{`RDAC_OFF_SWEEP, `RDAC_OFF_GAINMAP, `RDAC_OFF_FORCED, `RDAC_OFF_TLOOP, `RDAC_OFF_LPI})
		|=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!mgmt_rvalid |-> $stable(mgmt_rdata))
		else $error("read data moved without a read");
	coeff1_valid_a: assert property (forced_coeff1_valid ==
		($past(cable_class) == rdac_pkg::RDAC_CABLE_SHORT)) else $error("coeff1 valid wrong");
	coeff0_valid_a: assert property (forced_coeff0_valid == ($past(cable_class) inside
		{rdac_pkg::RDAC_CABLE_SHORT, rdac_pkg::RDAC_CABLE_LONG})) else $error("coeff0 valid wrong");
	active_nohold_a: assert property ($past(lpi_state) == rdac_pkg::RDAC_LPI_ACTIVE
		|-> !dfe_hold && !gain_blocks_hold) else $error("group hold while active");

endmodule : rdac_top_checker

bind rdac_top rdac_top_checker #(.COEFF_WIDTH(COEFF_WIDTH), .KP_WIDTH(KP_WIDTH),
	.KF_WIDTH(KF_WIDTH)) u_chk (.clock(clock), .sys_rst(sys_rst), .mgmt_req(mgmt_req),
	.mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .adapt_state(adapt_state),
	.sweep_iter_start(sweep_iter_start), .cable_class(cable_class), .lpi_state(lpi_state),
	.dfe_hold(dfe_hold), .gain_blocks_hold(gain_blocks_hold), .freqacc_clear(freqacc_clear),
	.dfe_coeff_reset(dfe_coeff_reset), .forced_coeff0_valid(forced_coeff0_valid),
	.forced_coeff1_valid(forced_coeff1_valid));
`default_nettype wire

// ---- rdac_top_tb.sv ----
// self-checking bench for the receiver adaptation config bank
`default_nettype none
`include "rdac_defs.svh"
module rdac_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                     clock = 1'b0;
	logic                     sys_rst = 1'b1;
	rdac_pkg::rdac_mgmt_type  mgmt_req = '0;
	rdac_pkg::rdac_adapt_type adapt_state = rdac_pkg::RDAC_ADAPT_IDLE;
	logic                     sweep_iter_start = 1'b0;
	rdac_pkg::rdac_cable_type cable_class = rdac_pkg::RDAC_CABLE_SHORT;
	rdac_pkg::rdac_lpi_type   lpi_state = rdac_pkg::RDAC_LPI_ACTIVE;
	logic [2:0]               adaptive_prop_gain = 3'h0;
	logic [3:0]               adaptive_integ_gain = 4'h0;
	logic                     adaptive_prop_hold = 1'b0;
	logic                     adaptive_integ_hold = 1'b0;
	logic [15:0]              mgmt_rdata;
	logic                     mgmt_rvalid, ffe_hold, dfe_hold, gain_blocks_hold;
	rdac_pkg::rdac_checks_type sweep_checks;
	logic                     precursor_metric_enable, freqacc_clear, dfe_coeff_reset;
	logic [1:0]               gain_map_sel;
	logic                     coeff_source_table, forced_coeff0_valid, forced_coeff1_valid;
	logic [7:0]               forced_coeff0, forced_coeff1;
	logic [2:0]               prop_gain;
	logic [3:0]               integ_gain;
	logic                     prop_arm_hold, integ_arm_hold, phase_detector_invert;
	logic                     energy_input_adc;
	logic [15:0] offs [5] = '{`RDAC_OFF_SWEEP, `RDAC_OFF_GAINMAP, `RDAC_OFF_FORCED,
		`RDAC_OFF_TLOOP, `RDAC_OFF_LPI};
	logic [15:0] masks [5] = '{`RDAC_WM_SWEEP, `RDAC_WM_GAINMAP, `RDAC_WM_FORCED,
		`RDAC_WM_TLOOP, `RDAC_WM_LPI};
	logic [15:0] rst_vals [5] = '{16'h0064, 16'h01fc, 16'h06f8, 16'h1101, 16'hfc36};
	logic [15:0] corner [3] = '{16'hffff, 16'h8000, 16'hc000};
	// holes beside the bank and one that differs only in the top address bit
	logic [15:0] holes [3] = '{16'h0310, 16'h031e, 16'h8311};
	logic [15:0] shadow [5];
	logic [15:0] rdv;
	int          seed = 12;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;
	int          i, k;

	rdac_top uut (.clock(clock), .sys_rst(sys_rst), .mgmt_req(mgmt_req),
		.mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .adapt_state(adapt_state),
		.sweep_iter_start(sweep_iter_start), .cable_class(cable_class), .lpi_state(lpi_state),
		.adaptive_prop_gain(adaptive_prop_gain), .adaptive_integ_gain(adaptive_integ_gain),
		.adaptive_prop_hold(adaptive_prop_hold), .adaptive_integ_hold(adaptive_integ_hold),
		.ffe_hold(ffe_hold), .dfe_hold(dfe_hold), .gain_blocks_hold(gain_blocks_hold),
		.sweep_checks(sweep_checks), .precursor_metric_enable(precursor_metric_enable),
		.freqacc_clear(freqacc_clear), .dfe_coeff_reset(dfe_coeff_reset),
		.gain_map_sel(gain_map_sel), .coeff_source_table(coeff_source_table),
		.forced_coeff0(forced_coeff0), .forced_coeff0_valid(forced_coeff0_valid),
		.forced_coeff1(forced_coeff1), .forced_coeff1_valid(forced_coeff1_valid),
		.prop_gain(prop_gain), .integ_gain(integ_gain), .prop_arm_hold(prop_arm_hold),
		.integ_arm_hold(integ_arm_hold), .phase_detector_invert(phase_detector_invert),
		.energy_input_adc(energy_input_adc));

	always #20 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
		checked++;
		if (seen !== expected)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, expected, seen);
		end
	endtask : check

	// a code of three in the gain map field is refused, the rest of the word lands
	function automatic logic [15:0] next_word(int idx, logic [15:0] old, logic [15:0] d);
		logic [15:0] w;
		w = d & masks[idx];
		if (idx == `RDAC_IDX_GAINMAP && d[15:14] == `RDAC_GAINMAP_ILLEGAL)
			w[15:14] = old[15:14];
		return w;
	endfunction : next_word

	task automatic wreg(input int idx, input logic [15:0] d);
		@(posedge clock);
		mgmt_req <= {offs[idx], d, 2'b10};
		@(posedge clock);
		mgmt_req <= '0;
		shadow[idx] = next_word(idx, shadow[idx], d);
	endtask : wreg

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clock);
		mgmt_req <= {a, 16'h0000, 2'b01};
		@(posedge clock);
		mgmt_req <= '0;
		#1;
		check("read valid", mgmt_rvalid, 1'b1);
		d = mgmt_rdata;
	endtask : rd

	task automatic check_outputs;
		logic [4:0] grp;
		logic [15:0] s, g, f, t, l;
		s = shadow[0];
		g = shadow[1];
		f = shadow[2];
		t = shadow[3];
		l = shadow[4];
		case (lpi_state)
			rdac_pkg::RDAC_LPI_HOLD: grp = l[15:11];
			rdac_pkg::RDAC_LPI_WAKE: grp = l[10:6];
			rdac_pkg::RDAC_LPI_FLUSH: grp = l[5:1];
			default: grp = 5'h00;
		endcase
		check("holds", {ffe_hold, prop_arm_hold, integ_arm_hold, dfe_hold, gain_blocks_hold},
			{(adapt_state == rdac_pkg::RDAC_ADAPT_FFE2 && s[6])
			|| (adapt_state == rdac_pkg::RDAC_ADAPT_FFE3 && s[5]) || grp[4],
			(t[6] ? t[5] : adaptive_prop_hold) | grp[2], (t[4] ? t[3] : adaptive_integ_hold)
			| grp[3], grp[1], grp[0]});
		check("gains", {prop_gain, integ_gain}, {t[15] ? t[13:11] : adaptive_prop_gain,
			t[14] ? t[10:7] : adaptive_integ_gain});
		check("coeffs", {forced_coeff0, forced_coeff0_valid, forced_coeff1, forced_coeff1_valid},
			{cable_class == rdac_pkg::RDAC_CABLE_LONG ? f[15:8] : g[8:1],
			cable_class != rdac_pkg::RDAC_CABLE_MID, f[7:0],
			cable_class == rdac_pkg::RDAC_CABLE_SHORT});
		check("selects", {sweep_checks, precursor_metric_enable, gain_map_sel, coeff_source_table,
			phase_detector_invert, energy_input_adc},
			{s[4:2], t[0], g[15:14], g[13], t[2], t[1]});
	endtask : check_outputs

	// reset mid-run as well, so stale register contents must be cleared
	task automatic do_reset;
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		shadow = rst_vals;
		#1;
		check_outputs();
		for (i = 0; i < 5; i++)
		begin
			rd(offs[i], rdv);
			check("reset value", rdv, rst_vals[i]);
		end
		$display("test reset values done");
	endtask : do_reset

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		do_reset();
		for (k = 0; k < 30; k++)
		begin
			i = $unsigned($random(seed)) % 5;
			rdv = 16'($random(seed));
			if (k < 3)
			begin
				i = `RDAC_IDX_GAINMAP;
				rdv = corner[k];
			end
			wreg(i, rdv);
			rd(offs[i], rdv);
			check("readback", rdv, shadow[i]);
		end
		wr_unmapped: for (k = 0; k < 3; k++)
		begin
			@(posedge clock);
			mgmt_req <= {holes[k], 16'hffff, 2'b10};
			@(posedge clock);
			mgmt_req <= '0;
			rd(holes[k], rdv);
			check("unmapped", rdv, 16'h0000);
		end
		// writes into holes must not alias onto any word of the bank
		for (i = 0; i < 5; i++)
		begin
			rd(offs[i], rdv);
			check("no alias", rdv, shadow[i]);
		end
		// a read beside a write in one cycle returns the word as it stood
		@(posedge clock);
		mgmt_req <= {offs[3], 16'h8000, 2'b11};
		@(posedge clock);
		mgmt_req <= '0;
		#1;
		check("same cycle read", mgmt_rdata, shadow[3]);
		shadow[3] = next_word(3, shadow[3], 16'h8000);
		rd(offs[3], rdv);
		check("same cycle write", rdv, shadow[3]);
		$display("test register access done");
		for (k = 0; k < 40; k++)
		begin
			for (i = 0; i < 5; i++)
				wreg(i, 16'($random(seed)));
			@(posedge clock);
			adapt_state <= rdac_pkg::rdac_adapt_type'(3'($unsigned($random(seed)) % 6));
			cable_class <= rdac_pkg::rdac_cable_type'(2'($unsigned($random(seed)) % 3));
			lpi_state <= rdac_pkg::rdac_lpi_type'(2'($random(seed)));
			{adaptive_prop_gain, adaptive_integ_gain, adaptive_prop_hold, adaptive_integ_hold}
				<= 9'($random(seed));
			repeat (2) @(posedge clock);
			#1;
			check_outputs();
		end
		$display("test steering done");
		for (k = 0; k < 8; k++)
		begin
			wreg(`RDAC_IDX_SWEEP, 16'($random(seed)));
			@(posedge clock);
			adapt_state <= k[0] ? rdac_pkg::RDAC_ADAPT_SWEEP : rdac_pkg::RDAC_ADAPT_STEADY;
			sweep_iter_start <= 1'b1;
			@(posedge clock);
			sweep_iter_start <= 1'b0;
			#1;
			check("sweep pulses", {freqacc_clear, dfe_coeff_reset},
				{2{k[0]}} & shadow[0][1:0]);
			@(posedge clock);
			#1;
			check("pulse end", {freqacc_clear, dfe_coeff_reset}, 2'b00);
		end
		$display("test sweep pulses done");
		do_reset();
		final_report();
	end

endmodule : rdac_top_tb
`default_nettype wire
